// File: logic/ldc_pkg.sv
// Constants, field layout and carrier types of the LCD display control stage.
// Assumes an 8-bit register port with 16-bit addresses and a 32.768 kHz subclock pin.
package ldc_pkg;

    // Register and LCD RAM addresses
    localparam logic [15:0] LDC_ADDR_CTRL     = 16'hffa1;
    localparam logic [15:0] LDC_ADDR_RAM_LO   = 16'hf370;
    localparam logic [15:0] LDC_ADDR_RAM_HI   = 16'hf37f;
    localparam int          LDC_RAM_WORDS     = 16;
    localparam int          LDC_RAM_AW        = 4;

    // Control register field positions
    localparam int          LDC_BIT_POWER_SW  = 6;
    localparam int          LDC_BIT_ACTIVATE  = 5;
    localparam int          LDC_BIT_DATA_SEL  = 4;
    localparam int          LDC_BIT_CLK_SEL3  = 3;
    localparam int          LDC_BIT_CLK_SEL2  = 2;
    localparam int          LDC_BIT_CLK_SEL1  = 1;
    localparam int          LDC_BIT_CLK_SEL0  = 0;
    localparam logic [7:0]  LDC_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  LDC_CTRL_WMASK    = 8'h7f;

    // Frame timing: operating-clock ticks per frame and per common phase
    localparam int          LDC_COMMONS       = 4;
    localparam int          LDC_SEGMENTS      = 32;
    localparam int          LDC_FRAME_BITS    = 8;
    localparam logic [7:0]  LDC_FRAME_TICKS_M1 = 8'hff;
    localparam int          LDC_PRESCALE_BITS = 7;

    // Subclock rate and system clock rate, for reference counts
    localparam int          LDC_SUBCLK_HZ     = 32768;
    localparam int          LDC_CLK_HZ        = 40000000;
    localparam int          LDC_FRAME_HZ      = 64;

    typedef struct packed {
        logic       reserved;
        logic       drive_power_switch;
        logic       controller_activate;
        logic       display_data_select;
        logic [3:0] frame_clock_select;
    } ldc_ctrl_t;

    typedef struct packed {
        logic [LDC_COMMONS-1:0]  com;
        logic [LDC_SEGMENTS-1:0] seg;
    } ldc_drive_t;

endpackage

// File: logic/ldc_display_control.sv
// Control stage of an LCD controller/driver: control register, LCD RAM,
// subclock-derived frame timing and common/segment scan outputs.
// Assumes the subclock arrives on a pin asynchronous to clk and that standby
// comes from chip logic on clk.
//
// Overview of operation
// (RULE1) Drive power switch bit one enables LCD drive power, zero disables it.
// (RULE2) Drive power forced off while activate bit is zero or chip is in standby.
// (RULE3) Activate bit 5 runs the controller; zero halts all controller operation.
// (RULE4) Halting keeps every register and RAM content for later resumption; here the prescaler and frame counter clear to zero on halt.
// (RULE5) Display select bit 4: one shows LCD RAM, zero shows blank segments.
// (RULE6) Frame clock select 0-01 gives subclock/2 and 64 Hz frame rate.
// (RULE7) LCD RAM writes appear on the display automatically while display is on.
// (RULE8) Frame timing divides the operating clock; scanning runs only while active.
`timescale 1ns/10ps
`default_nettype none

module ldc_display_control
    import ldc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Register port
    input  wire logic [15:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Chip state and subclock pin
    input  wire logic             standby,
    input  wire logic             subclk_pin,
    // Panel side
    output logic                  drive_power_on,
    output logic                  controller_running,
    output logic                  frame_start,
    output var ldc_drive_t        panel
);

    // Scan counters restart from zero on every halt, so the first frame after
    // a resume is always a whole one. Register and RAM contents survive a halt.
    // The LCD RAM has no reset: software must fill it before showing it.

    // Register state
    ldc_ctrl_t                  ctrl_q;
    logic [7:0]                 ram_q [LDC_RAM_WORDS];
    logic [7:0]                 rdata_q;

    // Subclock capture
    logic [2:0]                 sub_sync_q;
    logic                       sub_agree;
    logic                       sub_level_q;
    logic                       sub_edge;

    // Timing chain
    logic [LDC_PRESCALE_BITS-1:0] presc_q;
    logic [LDC_FRAME_BITS-1:0]  frame_cnt_q;
    logic                       op_tick;
    logic [LDC_PRESCALE_BITS-1:0] presc_limit;
    logic [1:0]                 phase;

    // Outputs held in flip-flops
    logic                       power_q;
    logic                       power_d;
    logic                       frame_start_q;
    logic                       frame_start_d;
    ldc_drive_t                 panel_q;
    ldc_drive_t                 panel_d;
    logic [LDC_COMMONS-1:0]     com_d;
    logic [LDC_SEGMENTS-1:0]    seg_d;

    // Next values of the register state
    ldc_ctrl_t                  ctrl_d;
    logic [7:0]                 rdata_d;
    logic [LDC_PRESCALE_BITS-1:0] presc_d;
    logic [LDC_FRAME_BITS-1:0]  frame_cnt_d;
    logic                       frame_wrap;

    // Access decode
    logic                       ctrl_sel;
    logic                       ram_sel;
    logic                       ctrl_wr;
    logic                       ctrl_rd;
    logic                       ram_wr;
    logic                       ram_rd;
    logic [LDC_RAM_AW-1:0]      ram_idx;
    logic                       active;

    // True when the address falls inside the LCD RAM window
    function automatic logic in_ram(input logic [15:0] a);
        in_ram = (a >= LDC_ADDR_RAM_LO) && (a <= LDC_ADDR_RAM_HI);
    endfunction

    // Operating clock divisor, as subclock edges per tick minus one.
    // Bit 2 is ignored; 0-01 gives subclock/2. Bit 3 adds a further /16.
    function automatic logic [LDC_PRESCALE_BITS-1:0] op_div_m1(input logic [3:0] cks);
        logic [LDC_PRESCALE_BITS-1:0] one;
        one = {{(LDC_PRESCALE_BITS-1){1'b0}}, 1'b1};
        if (cks[LDC_BIT_CLK_SEL3]) begin
            op_div_m1 = (one << (cks[1:0] + 3'd4)) - one;
        end else begin
            op_div_m1 = (one << cks[1:0]) - one;
        end
    endfunction

    // RAM word index inside the LCD RAM window
    function automatic logic [LDC_RAM_AW-1:0] ram_word(input logic [15:0] a);
        ram_word = a[LDC_RAM_AW-1:0];
    endfunction

    // Segment bit for a phase: even segments low nibble, odd ones high nibble
    function automatic logic scan_bit(input logic [7:0] word, input logic odd,
                                      input logic [1:0] ph);
        scan_bit = word[{odd, ph}];
    endfunction

    // Drive power only while switched on, running and awake
    function automatic logic power_allowed(input ldc_ctrl_t c, input logic sleep);
        power_allowed = c.drive_power_switch && c.controller_activate && !sleep;
    endfunction

    assign ctrl_sel = (reg_addr == LDC_ADDR_CTRL);
    assign ram_sel  = in_ram(reg_addr);
    assign ctrl_wr  = reg_wr && ctrl_sel;
    assign ctrl_rd  = reg_rd && ctrl_sel;
    assign ram_wr   = reg_wr && ram_sel;
    assign ram_rd   = reg_rd && ram_sel;
    assign ram_idx  = ram_word(reg_addr);
    assign active   = ctrl_q.controller_activate;

    // Control register; writes only, halting never clears it
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = reg_wdata & LDC_CTRL_WMASK; // [RULE3] [RULE4] [RULE5] [RULE6]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= LDC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // LCD RAM, written at any time and read by the scan directly
    always_ff @(posedge clk) begin
        if (ram_wr) begin
            ram_q[ram_idx] <= reg_wdata; // [RULE7] [RULE4]
        end
    end

    // Read data, valid the cycle after the strobe only; unmapped reads give zero
    always_comb begin
        rdata_d = 8'h00;
        if (ctrl_rd) begin
            rdata_d = ctrl_q;
        end else if (ram_rd) begin
            rdata_d = ram_q[ram_idx];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Subclock pin: three flops, edge counts once second and third agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_sync_q <= 3'h0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], subclk_pin};
        end
    end

    assign sub_agree = (sub_sync_q[1] == sub_sync_q[2]);

    // Settled subclock level, moved only when the two late stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_level_q <= 1'b0;
        end else if (sub_agree) begin
            sub_level_q <= sub_sync_q[2];
        end
    end

    assign sub_edge = sub_agree && sub_sync_q[2] && !sub_level_q;

    assign presc_limit = op_div_m1(ctrl_q.frame_clock_select);
    assign op_tick     = active && sub_edge && (presc_q >= presc_limit); // [RULE6]

    // Prescaler from subclock edges to operating clock ticks
    always_comb begin
        presc_d = presc_q;
        if (!active) begin
            presc_d = '0; // [RULE8]
        end else if (sub_edge) begin
            if (presc_q >= presc_limit) begin
                presc_d = '0;
            end else begin
                presc_d = presc_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_d;
        end
    end

    // Frame counter: 256 operating ticks per frame, 64 per common phase
    always_comb begin
        frame_cnt_d = frame_cnt_q;
        if (!active) begin
            frame_cnt_d = '0; // [RULE8] [RULE3]
        end else if (op_tick) begin
            frame_cnt_d = frame_cnt_q + 1'b1; // [RULE8]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_q <= '0;
        end else begin
            frame_cnt_q <= frame_cnt_d;
        end
    end

    assign phase         = frame_cnt_q[LDC_FRAME_BITS-1 -: 2];
    assign frame_wrap    = (frame_cnt_q == LDC_FRAME_TICKS_M1);
    assign frame_start_d = op_tick && frame_wrap;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= frame_start_d;
        end
    end

    // Common drive: one-hot on the current phase while running
    always_comb begin
        com_d = '0;
        if (active) begin
            com_d[phase] = 1'b1; // [RULE8]
        end
    end

    // Segment drive: segment 2k+h takes RAM word k bit phase+4h
    always_comb begin
        seg_d = '0;
        if (active && ctrl_q.display_data_select) begin
            for (int s = 0; s < LDC_SEGMENTS; s++) begin
                seg_d[s] = scan_bit(ram_q[s / 2], s[0], phase); // [RULE5] [RULE7]
            end
        end
    end

    assign panel_d = {com_d, seg_d};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_q <= '0;
        end else begin
            panel_q <= panel_d;
        end
    end

    // Drive power follows the switch unless halted or in standby.
    // Standby is taken straight from chip logic on clk, so no synchroniser.
    assign power_d = power_allowed(ctrl_q, standby); // [RULE1] [RULE2]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_q <= 1'b0;
        end else begin
            power_q <= power_d;
        end
    end

    assign drive_power_on     = power_q;
    assign controller_running = active;
    assign frame_start        = frame_start_q;
    assign panel              = panel_q;

endmodule // ldc_display_control

`default_nettype wire

// File: test/ldc_panel_model.sv
// Panel-side observer: measures the spacing of frame starts.
// Assumes clk is the system clock of the display control stage.
`timescale 1ns/10ps
`default_nettype none
module ldc_panel_model (
    // System side
    input  wire logic clk,
    input  wire logic frame_start,
    // Measured spacing
    output int        frame_gap,
    output int        frames
);
    int cnt = 0;
    initial frames = 0;
    always @(posedge clk) begin
        cnt <= frame_start ? 1 : cnt + 1;
        if (frame_start) begin
            frame_gap <= cnt;
            frames    <= frames + 1;
        end
    end
endmodule // ldc_panel_model
`default_nettype wire

// File: test/ldc_display_control_asserts.sv
// Port checks of the display control stage.
// Assumes one clock domain and registered panel and power outputs.
`timescale 1ns/10ps
`default_nettype none
module ldc_display_control_asserts
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    // Chip and panel
    input wire logic        standby,
    input wire logic        drive_power_on,
    input wire logic        controller_running,
    input wire logic        frame_start,
    input wire ldc_drive_t  panel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = reg_wr && reg_addr == LDC_ADDR_CTRL;
    a_power_on_switch: assert property (ctrl_wr && reg_wdata[6:5] == 2'b11 && !standby
        ##1 !standby && !reg_wr |=> drive_power_on) else $error("power stayed off");
    a_power_off_switch: assert property (ctrl_wr && !reg_wdata[6] ##1 !reg_wr
        |=> !drive_power_on) else $error("power on with switch off");
    a_power_off_halt: assert property (!controller_running |=> !drive_power_on)
        else $error("power on while halted");
    a_power_off_standby: assert property (standby |=> !drive_power_on)
        else $error("power on in standby");
    a_run_follows_bit: assert property (ctrl_wr |=> controller_running == $past(reg_wdata[5]))
        else $error("run flag wrong");
    a_halt_blank: assert property (!controller_running |=> panel == '0)
        else $error("panel active while halted");
    a_blank_seg: assert property (ctrl_wr && !reg_wdata[4] ##1 !reg_wr
        |=> panel.seg == 32'h0) else $error("segments not blank");
    a_frame_single: assert property (frame_start |=> !frame_start)
        else $error("frame pulse too long");
endmodule // ldc_display_control_asserts
`default_nettype wire

// File: test/tb_ldc_display_control.sv
// Self-checking bench for the LCD display control stage.
// Assumes a fast subclock of 8 clk periods so that frames fit a short run.
`timescale 1ns/10ps
`default_nettype none
bind ldc_display_control ldc_display_control_asserts u_chk (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .standby, .drive_power_on, .controller_running, .frame_start, .panel);
module tb_ldc_display_control
    import ldc_pkg::*;
;
    localparam int FRAME_CLKS = 2 * (int'(LDC_FRAME_TICKS_M1) + 1) * 8;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        standby = 1'b0, subclk_pin = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic        drive_power_on, controller_running, frame_start;
    ldc_drive_t  panel;
    int          miscompares = 0, comparisons = 0, cyc = 0, frame_gap, frames;
    always #12.5 clk = ~clk;
    always #100 subclk_pin = ~subclk_pin;
    ldc_display_control u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .standby, .subclk_pin, .drive_power_on, .controller_running,
        .frame_start, .panel);
    ldc_panel_model u_panel (.clk, .frame_start, .frame_gap, .frames);
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic wfr;
        int n;
        n = frames;
        for (int i = 0; i < 9000 && frames == n; i++) @(posedge clk);
        chk(frames != n, 1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(LDC_ADDR_CTRL, LDC_CTRL_RESET);
        wr(LDC_ADDR_CTRL, 8'hff);
        rd(LDC_ADDR_CTRL, 8'h7f);
        rd(16'h1234, 8'h00);
        for (int k = 0; k < 16; k++) wr(LDC_ADDR_RAM_LO + 16'(k), 8'h11);
        // Don't-care bit 2 set: still the divide-by-two rate
        wr(LDC_ADDR_CTRL, 8'h75);
        wfr();
        wfr();
        chk(frame_gap, FRAME_CLKS);
        settle(3);
        chk({panel.com, drive_power_on}, {4'h1, 1'b1});
        chk(panel.seg, 32'hffffffff);
        wr(LDC_ADDR_RAM_LO, 8'h12);
        settle(1100);
        chk({panel.com, panel.seg}, {4'h2, 32'h1});
        @(posedge clk) standby <= 1'b1;
        settle(2);
        chk(drive_power_on, 0);
        @(posedge clk) standby <= 1'b0;
        settle(2);
        chk(drive_power_on, 1);
        wr(LDC_ADDR_CTRL, 8'h65);
        settle(2);
        chk(panel.seg, 32'h0);
        wr(LDC_ADDR_CTRL, 8'h35);
        settle(2);
        chk(drive_power_on, 0);
        wr(LDC_ADDR_CTRL, 8'h55);
        settle(2);
        chk({drive_power_on, controller_running, panel.com}, 0);
        rd(LDC_ADDR_CTRL, 8'h55);
        rd(LDC_ADDR_RAM_LO, 8'h12);
        complete_run();
    end
endmodule // tb_ldc_display_control
`default_nettype wire
